// [qbp_regs.vh]
// Constants for the quasi-bidirectional port pair.
// Assumes inclusion by qbp_port.v and qbp_bit.v only.
`ifndef QBP_REGS_VH
`define QBP_REGS_VH

// Latch reset value: all ones, weak pullup only
`define QBP_LATCH_RESET    8'hff
// Strong transition driver time in ns and cycles at 40 MHz
`define QBP_CLK_NS         25
`define QBP_KICK_NS        25
`define QBP_KICK_CYCLES    ((`QBP_KICK_NS + `QBP_CLK_NS - 1) / `QBP_CLK_NS)
// Alternate function bit positions on the upper port
`define QBP_UP_A20_BIT     4
`define QBP_UP_TX_BIT      7

`endif

// [qbp_bit.v]
// One quasi-bidirectional pin driver: latch, pulldown, kick, weak pullup.
// Assumes a synchronous write strobe and a pin level synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "qbp_regs.vh"

module qbp_bit #(
	parameter KICK_CYCLES = `QBP_KICK_CYCLES
) (
	// Clock and reset
	input  wire clk,
	input  wire rst,
	// Software side
	input  wire wr,
	input  wire wdata,
	// Alternate function override
	input  wire alt_en,
	input  wire alt_val,
	// Pin drive
	output reg  latch,
	output reg  strong_lo,
	output reg  strong_hi,
	output reg  weak_hi
);

	reg [7:0] kick;
	wire      drive_val;
	wire      next_latch;

	assign next_latch = wr ? wdata : latch;
	// Alternate function ignores the latch
	assign drive_val  = alt_en ? alt_val : next_latch;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			latch     <= 1'b1;
			kick      <= 8'h00;
			strong_lo <= 1'b0;
			strong_hi <= 1'b0;
			weak_hi   <= 1'b1;
		end else begin
			latch <= next_latch;
			// Kick on any 0-to-1 of the driven value, latch or alternate
			if (drive_val && !strong_lo && !weak_hi) begin
				kick <= KICK_CYCLES[7:0];
			end else if (drive_val && strong_lo) begin
				kick <= KICK_CYCLES[7:0];
			end else if (kick != 8'h00) begin
				kick <= kick - 8'h01;
			end
			strong_lo <= !drive_val;
			strong_hi <= drive_val && (strong_lo ||
				(kick > 8'h01));
			weak_hi   <= drive_val;
		end
	end

endmodule
`default_nettype wire

// [qbp_port.v]
// Two 8-bit quasi-bidirectional ports: low-address port and upper port.
// Assumes software write strobes and pin levels synchronous to clk; the
// testbench resolves each pin from strong/weak drives and external load.
// Overview of operation
// - Low port is plain I/O; strap high makes it drive low address byte.
// - After reset every bit holds 1 with only the weak pullup on.
// - A bit at 1 is an input; external drive wins, level reads back.
// - Writing 0 turns on strong pulldown until a 1 or reset.
// - Writing 1 after 0 pulses strong high driver, then weak pullup.
// - In address mode low port bit n carries address bit n.
// - Upper port bit 4 alternate function outputs address line 20.
// - Upper port bit 7 alternate function outputs third serial transmit.
// - Upper port serves as I/O, address line 20 output and/or serial port.
`timescale 1ns/100ps
`default_nettype none
`include "qbp_regs.vh"

module qbp_port #(
	parameter WIDTH       = 8,
	parameter KICK_CYCLES = `QBP_KICK_CYCLES
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Mode strap and alternate enables
	input  wire             addr_mode_strap,
	input  wire             up_a20_en,
	input  wire             up_tx_en,
	// Alternate function sources
	input  wire [WIDTH-1:0] low_addr_byte,
	input  wire             upper_addr_line_20,
	input  wire             third_uart_tx,
	// Low port software side
	input  wire             low_wr,
	input  wire [WIDTH-1:0] low_wdata,
	// Upper port software side
	input  wire             up_wr,
	input  wire [WIDTH-1:0] up_wdata,
	// Pin levels as seen on the wire
	input  wire [WIDTH-1:0] low_pin_in,
	input  wire [WIDTH-1:0] up_pin_in,
	// Low port pin drives
	output wire [WIDTH-1:0] low_strong_lo,
	output wire [WIDTH-1:0] low_strong_hi,
	output wire [WIDTH-1:0] low_weak_hi,
	// Upper port pin drives
	output wire [WIDTH-1:0] up_strong_lo,
	output wire [WIDTH-1:0] up_strong_hi,
	output wire [WIDTH-1:0] up_weak_hi,
	// Software read-back
	output reg  [WIDTH-1:0] low_latch_rd,
	output reg  [WIDTH-1:0] up_latch_rd,
	output reg  [WIDTH-1:0] low_pin_rd,
	output reg  [WIDTH-1:0] up_pin_rd
);

////////////////////////////////////////////////////////////////////////
	wire [WIDTH-1:0] low_latch;
	wire [WIDTH-1:0] up_latch;
	wire [WIDTH-1:0] up_alt_en;
	wire [WIDTH-1:0] up_alt_val;
	reg  [WIDTH-1:0] low_alt_en;

	// Strap is caught after release, never under the async reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			low_alt_en <= {WIDTH{1'b0}};
		end else begin
			low_alt_en <= {WIDTH{addr_mode_strap}};
		end
	end

	// Only bits 4 and 7 of the upper port have alternates modelled here
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_up
			if (i == `QBP_UP_A20_BIT) begin : g_a20
				assign up_alt_en[i]  = up_a20_en;
				assign up_alt_val[i] = upper_addr_line_20;
			end else if (i == `QBP_UP_TX_BIT) begin : g_tx
				assign up_alt_en[i]  = up_tx_en;
				assign up_alt_val[i] = third_uart_tx;
			end else begin : g_io
				assign up_alt_en[i]  = 1'b0;
				assign up_alt_val[i] = 1'b1;
			end
		end
	endgenerate

////////////////////////////////////////////////////////////////////////
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			qbp_bit #(
				.KICK_CYCLES(KICK_CYCLES)
			) u_low (
				.clk      (clk),
				.rst      (rst),
				.wr       (low_wr),
				.wdata    (low_wdata[i]),
				.alt_en   (low_alt_en[i]),
				.alt_val  (low_addr_byte[i]),
				.latch    (low_latch[i]),
				.strong_lo(low_strong_lo[i]),
				.strong_hi(low_strong_hi[i]),
				.weak_hi  (low_weak_hi[i])
			);
			qbp_bit #(
				.KICK_CYCLES(KICK_CYCLES)
			) u_up (
				.clk      (clk),
				.rst      (rst),
				.wr       (up_wr),
				.wdata    (up_wdata[i]),
				.alt_en   (up_alt_en[i]),
				.alt_val  (up_alt_val[i]),
				.latch    (up_latch[i]),
				.strong_lo(up_strong_lo[i]),
				.strong_hi(up_strong_hi[i]),
				.weak_hi  (up_weak_hi[i])
			);
		end
	endgenerate

////////////////////////////////////////////////////////////////////////
	// Read-back registered; pin reads give the external level
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			low_latch_rd <= `QBP_LATCH_RESET;
			up_latch_rd  <= `QBP_LATCH_RESET;
			low_pin_rd   <= `QBP_LATCH_RESET;
			up_pin_rd    <= `QBP_LATCH_RESET;
		end else begin
			low_latch_rd <= low_latch;
			up_latch_rd  <= up_latch;
			low_pin_rd   <= low_pin_in;
			up_pin_rd    <= up_pin_in;
		end
	end

endmodule
`default_nettype wire

// [qbp_port_assertions.sv]
// Checker on the pin drives of the port pair and the upper port pin read-back.
// Assumes a one-cycle kick and alternates on upper bits 4 and 7.
`timescale 1ns/100ps
`default_nettype none
module qbp_port_assertions #(parameter WIDTH = 8) (
	// Clock, reset, modes
	input wire logic             clk, rst, addr_mode_strap, up_a20_en,
	input wire logic             up_tx_en, upper_addr_line_20, third_uart_tx,
	input wire logic             up_wr,
	// Data and drives
	input wire logic [WIDTH-1:0] low_addr_byte, up_wdata, up_pin_in,
	input wire logic [WIDTH-1:0] low_strong_lo, up_strong_lo, up_strong_hi,
	input wire logic [WIDTH-1:0] up_weak_hi, up_pin_rd
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rst_weak:
	assert property ($fell(rst) |-> up_weak_hi == 8'hff && up_strong_lo == 0)
		else $error("reset drive wrong");
	a_wr0_pull:
	assert property (up_wr && !up_wdata[0] |=> up_strong_lo[0] && !up_weak_hi[0])
		else $error("pulldown missing");
	a_pull_hold:
	assert property (up_strong_lo[1] && !(up_wr && up_wdata[1]) |=> up_strong_lo[1])
		else $error("pulldown dropped");
	a_kick_once:
	assert property (up_wr && up_wdata[2] && up_strong_lo[2]
		|=> up_strong_hi[2] && !up_strong_lo[2] ##1 !up_strong_hi[2])
		else $error("kick wrong");
	a_no_kick:
	assert property (up_wr && up_wdata[3] && up_weak_hi[3] && !up_strong_hi[3]
		|=> !up_strong_hi[3]) else $error("spurious kick");
	a_pin_read:
	assert property (!$past(rst) |-> up_pin_rd == $past(up_pin_in))
		else $error("pin read wrong");
	a_addr_byte:
	assert property (!$past(rst) && !$past(rst, 2) && $past(addr_mode_strap)
		&& $past(addr_mode_strap, 2) |-> low_strong_lo == ~$past(low_addr_byte))
		else $error("address byte wrong");
	a_a20_alt:
	assert property ($past(up_a20_en) && !$past(rst)
		|-> up_strong_lo[4] == !$past(upper_addr_line_20))
		else $error("a20 wrong");
	a_tx_alt:
	assert property ($past(up_tx_en) && !$past(rst)
		|-> up_strong_lo[7] == !$past(third_uart_tx)) else $error("tx wrong");
endmodule
bind qbp_port qbp_port_assertions #(.WIDTH(WIDTH)) u_chk (.clk(clk),
	.rst(rst), .addr_mode_strap(addr_mode_strap), .up_a20_en(up_a20_en),
	.up_tx_en(up_tx_en), .upper_addr_line_20(upper_addr_line_20),
	.third_uart_tx(third_uart_tx), .up_wr(up_wr), .low_addr_byte(low_addr_byte),
	.up_wdata(up_wdata), .up_pin_in(up_pin_in), .low_strong_lo(low_strong_lo),
	.up_strong_lo(up_strong_lo), .up_strong_hi(up_strong_hi),
	.up_weak_hi(up_weak_hi), .up_pin_rd(up_pin_rd));
`default_nettype wire

// [qbp_pin_model.sv]
// Resolves eight pins from the drives and an external circuit.
// Assumes strong drives beat the load, the load beats the weak pullup.
`timescale 1ns/100ps
`default_nettype none
module qbp_pin_model (
	input wire logic [7:0] slo, shi, whi, ext_en, ext_val,
	output wire logic [7:0] pin
);
	// Floating pin shows the inverse, so a stale level never passes
	assign pin = ~slo & (shi | (ext_en & ext_val) |
		(~ext_en & (whi | ~ext_val)));
endmodule
`default_nettype wire

// [quasi_bidir_port_addr_pins_test.sv]
// Self-checking bench for the port pair with pin models.
// Assumes one-cycle kick and read-back one cycle late.
`timescale 1ns/100ps
`default_nettype none
module quasi_bidir_port_addr_pins_test;
	logic clk = 0, rst = 1, strap = 0, a20_en = 0, tx_en = 0, a20 = 0, tx = 0;
	logic lwr = 0, uwr = 0;
	logic [7:0] addr = 0, lwd = 0, uwd = 0, lx_en = 0, lx_v = 0, ux_en = 0;
	logic [7:0] ux_v = 0, prev, prevl;
	wire [7:0] lpin, upin, lslo, lshi, lwhi, uslo, ushi, uwhi, llr, ulr, lpr, upr;
	int err_total = 0, compares = 0, i;
	logic [31:0] rs = 32'h62f2556e;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	initial forever #12.5 clk = ~clk;
	qbp_port DUT (.clk(clk), .rst(rst), .addr_mode_strap(strap),
		.up_a20_en(a20_en), .up_tx_en(tx_en), .low_addr_byte(addr),
		.upper_addr_line_20(a20), .third_uart_tx(tx), .low_wr(lwr),
		.low_wdata(lwd), .up_wr(uwr), .up_wdata(uwd), .low_pin_in(lpin),
		.up_pin_in(upin), .low_strong_lo(lslo), .low_strong_hi(lshi),
		.low_weak_hi(lwhi), .up_strong_lo(uslo), .up_strong_hi(ushi),
		.up_weak_hi(uwhi), .low_latch_rd(llr), .up_latch_rd(ulr),
		.low_pin_rd(lpr), .up_pin_rd(upr));
	qbp_pin_model lpm (.slo(lslo), .shi(lshi), .whi(lwhi), .ext_en(lx_en),
		.ext_val(lx_v), .pin(lpin));
	qbp_pin_model upm (.slo(uslo), .shi(ushi), .whi(uwhi), .ext_en(ux_en),
		.ext_val(ux_v), .pin(upin));
	task chk(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task conclude;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task nxt; @(negedge clk); endtask
	// Low port gets the complement so both ports see activity
	task wr(input logic [7:0] d);
		uwd = d; lwd = ~d; uwr = 1; lwr = 1; nxt; uwr = 0; lwr = 0;
	endtask
	initial begin
		repeat (16) nxt;
		rst = 0; nxt;
		chk(uwhi, 8'hff);
		chk(uslo, 8'h00);
		chk(ulr, 8'hff);
		chk(lpr, 8'hff);
		$display("test reset done");
		prev = 8'hff;
		prevl = 8'hff;
		for (i = 0; i < 24; i++) begin
			rs = lfsr(rs); wr(rs[7:0]);
			chk(uslo, ~rs[7:0]);
			chk(lslo, rs[7:0]);
			chk(uwhi, rs[7:0]);
			chk(lwhi, ~rs[7:0]);
			chk(ushi, rs[7:0] & ~prev);
			chk(lshi, ~rs[7:0] & ~prevl);
			nxt;
			chk(ushi, 8'h00);
			chk(lshi, 8'h00);
			chk(ulr, rs[7:0]);
			chk(llr, ~rs[7:0]);
			ux_en = rs[15:8]; ux_v = rs[23:16]; lx_en = rs[31:24]; nxt; nxt;
			chk(upr, rs[7:0] & (~rs[15:8] | rs[23:16]));
			chk(lpr, ~rs[7:0] & ~rs[31:24]);
			prev = rs[7:0];
			prevl = ~rs[7:0];
		end
		$display("test io done");
		a20_en = 1; tx_en = 1; wr(8'h00);
		for (i = 0; i < 8; i++) begin
			rs = lfsr(rs); a20 = rs[0]; tx = rs[1]; nxt; nxt;
			chk(uslo, {~tx, 2'b11, ~a20, 4'hf});
		end
		$display("test alternate done");
		strap = 1;
		for (i = 0; i < 8; i++) begin
			rs = lfsr(rs); addr = rs[7:0]; nxt; nxt;
			chk(lslo, ~addr);
		end
		$display("test strap done");
		conclude;
	end
	initial begin
		#200000;
		err_total++;
		conclude;
	end
endmodule
`default_nettype wire
